// ### rtl/ipmc_top.v
`timescale 1ns/10ps
`include "ipmc_defines.vh"
module ipmc_top #(
  parameter TIMER_PERIOD = `IPMC_TIMER_PERIOD
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // core side
  input wire store_imm,
  output reg core_run,
  output reg wake_pulse,
  // power domains
  output reg osc_en,
  output reg watchdog_en,
  output reg base_timer_en,
  output reg low_supply_detector_en,
  output reg supply_dip_reset_en,
  output reg periph_en
);
  localparam ST_RUN = 2'b01;
  localparam ST_IDLE = 2'b10;

  reg [1:0] state;
  reg [7:0] wake_input_enable_register;
  reg [7:0] power_mode_clear_register;
  reg woke;
  reg [11:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  wire overflow;

  ipmc_base_timer #(
    .PERIOD(TIMER_PERIOD),
    .W(`IPMC_TIMER_W)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .overflow(overflow)
  );

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire hit_ctrl = do_write && aw_addr == `IPMC_OFF_STOP_CTRL;
  wire idle_req = hit_ctrl && w_strb[0] && w_data[`IPMC_BIT_IDLE_REQ] && store_imm;
  wire in_idle = state == ST_IDLE;

  function mapped;
    input [11:0] a;
    begin
      mapped = a == `IPMC_OFF_STOP_CTRL || a == `IPMC_OFF_WAKE_EN ||
               a == `IPMC_OFF_MODE_CLR || a == `IPMC_OFF_STATUS;
    end
  endfunction

  // write channels taken in either order
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPMC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `IPMC_RESP_OKAY : `IPMC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // software registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_input_enable_register <= `IPMC_RST_WAKE_EN;
      power_mode_clear_register <= `IPMC_RST_MODE_CLR;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == `IPMC_OFF_WAKE_EN)
        wake_input_enable_register <= w_data[7:0];
      // clear accepted only from immediate store
      if (aw_addr == `IPMC_OFF_MODE_CLR && store_imm)
        power_mode_clear_register <= w_data[7:0];
    end
  end

  // idle sequencer
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      woke <= 1'b0;
      core_run <= 1'b1;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      case (state)
        ST_RUN: begin
          if (do_write && aw_addr == `IPMC_OFF_MODE_CLR && store_imm)
            woke <= 1'b0;
          if (idle_req) begin
            state <= ST_IDLE;
            core_run <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (overflow) begin
            state <= ST_RUN;
            core_run <= 1'b1;
            wake_pulse <= 1'b1;
            woke <= 1'b1;
          end
        end
        default: begin
          state <= ST_RUN;
          core_run <= 1'b1;
        end
      endcase
    end
  end

  // power domain enables
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_en <= 1'b1;
      watchdog_en <= 1'b1;
      base_timer_en <= 1'b1;
      low_supply_detector_en <= 1'b1;
      supply_dip_reset_en <= 1'b1;
      periph_en <= 1'b1;
    end else begin
      osc_en <= 1'b1;
      watchdog_en <= 1'b1;
      base_timer_en <= 1'b1;
      // shed monitors in idle
      // a request landing while idle must not keep monitors off past the wake
      low_supply_detector_en <= !((in_idle && !overflow) || (!in_idle && idle_req));
      supply_dip_reset_en <= !((in_idle && !overflow) || (!in_idle && idle_req));
      periph_en <= !((in_idle && !overflow) || (!in_idle && idle_req));
    end
  end

  // read channel; idle request bit reads as zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IPMC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `IPMC_RESP_OKAY : `IPMC_RESP_SLVERR;
        case (s_axi_araddr)
          `IPMC_OFF_STOP_CTRL: s_axi_rdata <= 32'h0000_0000;
          `IPMC_OFF_WAKE_EN: s_axi_rdata <= {24'h00_0000, wake_input_enable_register};
          `IPMC_OFF_MODE_CLR: s_axi_rdata <= {24'h00_0000, power_mode_clear_register};
          `IPMC_OFF_STATUS: s_axi_rdata <= {29'h0000_0000,
            wake_input_enable_register != 8'h00, woke, in_idle};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ### rtl/ipmc_defines.vh
`ifndef IPMC_DEFINES_VH
`define IPMC_DEFINES_VH
// register byte offsets
`define IPMC_OFF_STOP_CTRL 12'h000
`define IPMC_OFF_WAKE_EN 12'h004
`define IPMC_OFF_MODE_CLR 12'h008
`define IPMC_OFF_STATUS 12'h00C
// stop-mode control fields
`define IPMC_BIT_IDLE_REQ 0
// status fields
`define IPMC_BIT_ST_IDLE 0
`define IPMC_BIT_ST_WOKE 1
`define IPMC_BIT_ST_WAKE_EN_BAD 2
// reset values
`define IPMC_RST_WAKE_EN 8'h00
`define IPMC_RST_MODE_CLR 8'h00
// base timer period in clock cycles
`define IPMC_TIMER_PERIOD 8192
`define IPMC_TIMER_W 13
// axi responses
`define IPMC_RESP_OKAY 2'b00
`define IPMC_RESP_SLVERR 2'b10
`endif

// ### rtl/ipmc_base_timer.v
`timescale 1ns/10ps
`include "ipmc_defines.vh"
module ipmc_base_timer #(
  parameter PERIOD = `IPMC_TIMER_PERIOD,
  parameter W = `IPMC_TIMER_W
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // overflow strobe
  output reg overflow
);
  reg [W-1:0] count;

  // free running: idle never stops it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
      overflow <= 1'b0;
    end else begin
      if (count == PERIOD[W-1:0] - 1'b1) begin
        count <= {W{1'b0}};
        overflow <= 1'b1;
      end else begin
        count <= count + 1'b1;
        overflow <= 1'b0;
      end
    end
  end
endmodule

// ### test/ipmc_asserts.sv
`timescale 1ns/10ps
module ipmc_asserts #(
  parameter TIMER_PERIOD = 8192
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // bus and core
  input wire s_axi_bvalid,
  input wire core_run,
  input wire wake_pulse,
  // power domains
  input wire osc_en,
  input wire watchdog_en,
  input wire base_timer_en,
  input wire low_supply_detector_en,
  input wire supply_dip_reset_en,
  input wire periph_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire mon = low_supply_detector_en | supply_dip_reset_en | periph_en;
  integer idle_cnt;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) idle_cnt <= 0;
    else idle_cnt <= core_run ? 0 : idle_cnt + 1;
  end
  property p_keep; osc_en && watchdog_en && base_timer_en; endproperty
  a_keep: assert property (p_keep) else $error("kept domain off");
  property p_off; !core_run |-> !mon; endproperty
  a_off: assert property (p_off) else $error("monitor on while idle");
  property p_on; core_run |-> low_supply_detector_en && supply_dip_reset_en && periph_en;
  endproperty
  a_on: assert property (p_on) else $error("monitor off while running");
  // free-running timer: idle never outlasts one period
  property p_dur; idle_cnt <= TIMER_PERIOD; endproperty
  a_dur: assert property (p_dur) else $error("idle too long");
  property p_wake; $rose(core_run) |-> wake_pulse; endproperty
  a_wake: assert property (p_wake) else $error("resume without pulse");
  property p_pulse; wake_pulse |-> core_run && !$past(core_run); endproperty
  a_pulse: assert property (p_pulse) else $error("pulse without resume");
  property p_one; wake_pulse |=> !wake_pulse; endproperty
  a_one: assert property (p_one) else $error("pulse too wide");
  property p_entry; $fell(core_run) |-> $rose(s_axi_bvalid); endproperty
  a_entry: assert property (p_entry) else $error("idle without write");
  c_enter: cover property ($fell(core_run));
  c_leave: cover property ($rose(core_run));
  c_write: cover property ($rose(s_axi_bvalid));
endmodule
bind ipmc_top ipmc_asserts #(.TIMER_PERIOD(TIMER_PERIOD)) u_chk (.clock, .rst_n,
  .s_axi_bvalid, .core_run, .wake_pulse, .osc_en, .watchdog_en, .base_timer_en,
  .low_supply_detector_en, .supply_dip_reset_en, .periph_en);

// ### test/ipmc_sw.sv
`timescale 1ns/10ps
module ipmc_sw (
  // clock
  input wire clock,
  // write side
  output reg [11:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  // read side
  output reg [11:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready,
  // store kind
  output reg store_imm
);
  integer n;
  // ready held high: never stalls answers, so no bready toggling
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = 0;
    {s_axi_araddr, s_axi_arvalid, store_imm} = 0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end
  task wr(input [11:0] a, input [7:0] d, input si, output [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'h1;
      store_imm <= si;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid && n < 99);
      r = s_axi_bresp;
      if (n > 98) tb_top.hang;
    end
  endtask
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid && n < 99);
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n > 98) tb_top.hang;
    end
  endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/10ps
`include "ipmc_defines.vh"
module tb_top;
  localparam integer tp = 16;
  reg clock;
  reg rst_n;
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, store_imm, core_run;
  wire wake_pulse, osc_en, watchdog_en, base_timer_en;
  wire low_supply_detector_en, supply_dip_reset_en, periph_en;
  integer error_cnt, n_checks, i, n, m, m_wen, m_woke, cyc;
  reg [31:0] d;
  reg [1:0] r;
  reg [7:0] v;
  ipmc_top #(.TIMER_PERIOD(tp)) DUT (.*);
  // edges since reset release; base timer overflows on a fixed grid of these
  always @(posedge clock) cyc <= rst_n ? cyc + 1 : 0;
  ipmc_sw sw (.*);
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        $display("wrong value t=%0t got %h exp %h", $time, g, e);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  task hang;
    begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  endtask
  task rs;
    begin
      sw.rd(`IPMC_OFF_STATUS, d, r);
      chk(d, (m_wen != 0) * 4 + m_woke * 2);
    end
  endtask
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  initial begin
    {error_cnt, n_checks, m_wen, m_woke} = 0;
    rst_n = 1'h0;
    v = 8'($urandom(64));
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    sw.rd(`IPMC_OFF_WAKE_EN, d, r);
    chk(d, `IPMC_RST_WAKE_EN);
    sw.wr(12'h010, 8'h01, 1'h1, r);
    chk(r, `IPMC_RESP_SLVERR);
    sw.wr(`IPMC_OFF_WAKE_EN, v, 1'($urandom), r);
    m_wen = v;
    sw.rd(`IPMC_OFF_WAKE_EN, d, r);
    chk(d, m_wen);
    rs;
    // plain store must not enter idle
    sw.wr(`IPMC_OFF_STOP_CTRL, 8'h01, 1'h0, r);
    n = 0;
    repeat (20) @(posedge clock) n = n + (core_run !== 1'h1);
    chk(n, 0);
    $display("test setup done");
    for (i = 0; i < 3; i = i + 1) begin
      sw.wr(`IPMC_OFF_WAKE_EN, 8'h00, 1'h1, r);
      m_wen = 0;
      sw.wr(`IPMC_OFF_STOP_CTRL, 8'h01, 1'h1, r);
      {n, m} = 0;
      // look before waiting: a wake on the very next edge leaves one idle cycle
      do begin
        if (core_run === 1'h0) begin
          m = m + 1;
          chk(periph_en | low_supply_detector_en | supply_dip_reset_en, 0);
          chk(osc_en & watchdog_en & base_timer_en, 1);
        end
        @(posedge clock);
        n = n + 1;
      end while (wake_pulse !== 1'h1 && n < 40);
      if (n > 39) hang;
      chk(core_run, 1);
      chk(m > 0, 1);
      chk(m <= tp, 1);
      chk(cyc % tp, 1);
      m_woke = 1;
      sw.rd(`IPMC_OFF_STOP_CTRL, d, r);
      chk(d, 0);
      sw.wr(`IPMC_OFF_MODE_CLR, 8'h00, 1'h0, r);
      rs;
      sw.wr(`IPMC_OFF_MODE_CLR, 8'h00, 1'h1, r);
      m_woke = 0;
      rs;
      $display("test idle %0d done", i);
    end
    summarize;
  end
endmodule
